/* File: rtl/cmc_event_nest.sv */
`timescale 1ns/1ps
module cmc_event_nest
    import cmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic self_nest_enable,
    input wire logic global_interrupt_enable,
    input wire logic nested_interrupt_enable,
    input wire logic system_event_irq_req,
    input wire logic system_event_irq_ack,
    input wire logic event_in_service,
    input wire logic higher_in_service,
    output logic latched_q,
    output logic event_mask_q,
    output logic lower_mask_q
);

    logic latched_d;
    logic event_mask_d;
    logic lower_mask_d;
    logic nest_open;

    always_comb begin
        nest_open = self_nest_enable & global_interrupt_enable & nested_interrupt_enable;
        // New request latches unless in service without self nesting; set beats ack
        latched_d = (system_event_irq_req & (~event_in_service | self_nest_enable)) |
                    (latched_q & ~system_event_irq_ack);
        // In service: stays open only in full nesting mode and not preempted
        event_mask_d = event_in_service & (higher_in_service | ~nest_open);
        lower_mask_d = event_in_service;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            latched_q <= 1'h0;
            event_mask_q <= 1'h0;
            lower_mask_q <= 1'h0;
        end else begin
            latched_q <= latched_d;
            event_mask_q <= event_mask_d;
            lower_mask_q <= lower_mask_d;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_self_nest_latch: assert property (
        system_event_irq_req && event_in_service && self_nest_enable |=> latched_q)
        else $error("self nested request not latched");

    a_no_nest_block: assert property (
        system_event_irq_req && event_in_service && !self_nest_enable && !latched_q |=> !latched_q)
        else $error("request latched while in service without self nesting");

    a_nest_unmask: assert property (
        event_in_service && nest_open && !higher_in_service |=> !event_mask_q && lower_mask_q)
        else $error("nesting mode masks wrong interrupts");

    a_preempt_mask: assert property (
        event_in_service && higher_in_service |=> event_mask_q)
        else $error("preempted event interrupt left unmasked");

endmodule : cmc_event_nest

/* File: rtl/cmc_mode_ctrl.sv */
`timescale 1ns/1ps
module cmc_mode_ctrl
    import cmc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic long_access_unaligned,
    input wire logic illegal_reg_access,
    input wire logic loop_opcode_early,
    input wire logic global_interrupt_enable,
    input wire logic nested_interrupt_enable,
    input wire logic system_event_irq_req,
    input wire logic system_event_irq_ack,
    input wire logic event_in_service,
    input wire logic higher_in_service,
    output logic conflict_cache_freeze,
    output logic conflict_cache_disable,
    output logic cache_fill_allow,
    output logic slow_loop_debug,
    output logic late_stage_loop_mode,
    output logic core_timer_run,
    output logic event_irq_self_nest_enable,
    output logic system_event_irq_latched,
    output logic system_event_irq_masked,
    output logic lower_irq_masked,
    output logic irq
);

    logic [31:0] mode_q;
    logic [31:0] mode_d;
    logic [1:0] status_q;
    logic [1:0] status_d;
    logic [1:0] mask_q;
    logic [1:0] mask_d;
    logic [1:0] evt_set;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic irq_q;
    logic irq_d;
    logic fill_q;
    logic fill_d;
    logic late_q;
    logic late_d;
    logic nest_latched;
    logic nest_event_mask;
    logic nest_lower_mask;
    logic wr_mode;
    logic wr_status;
    logic wr_mask;

    // Register writes and sticky events
    always_comb begin
        wr_mode = reg_wr & cmc_hit(reg_addr, CMC_OFF_MODE2);
        wr_status = reg_wr & cmc_hit(reg_addr, CMC_OFF_STATUS);
        wr_mask = reg_wr & cmc_hit(reg_addr, CMC_OFF_MASK);
        mode_d = mode_q;
        if (wr_mode) begin
            mode_d = reg_wdata & CMC_MODE2_WMASK;
        end
        evt_set = '0;
        evt_set[CMC_EVT_UNALIGNED] = long_access_unaligned & mode_q[CMC_BIT_UNALIGNED_EN];
        evt_set[CMC_EVT_ILLEGAL] = illegal_reg_access & mode_q[CMC_BIT_ILLEGAL_EN];
        // Write one clears, a new event in the same cycle wins
        status_d = status_q;
        if (wr_status) begin
            status_d = status_q & ~reg_wdata[1:0];
        end
        status_d = status_d | evt_set;
        mask_d = mask_q;
        if (wr_mask) begin
            mask_d = reg_wdata[1:0];
        end
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            mode_q <= CMC_MODE2_RESET;
            status_q <= CMC_EVT_RESET;
            mask_q <= CMC_EVT_RESET;
            irq_q <= 1'h0;
        end else begin
            mode_q <= mode_d;
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    // Derived control for cache and loop sequencer
    always_comb begin
        fill_d = ~mode_d[CMC_BIT_CACHE_FREEZE] & ~mode_d[CMC_BIT_CACHE_DISABLE];
        late_d = mode_q[CMC_BIT_SLOW_LOOP] | ~loop_opcode_early;
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fill_q <= 1'h1;
            late_q <= 1'h1;
        end else begin
            fill_q <= fill_d;
            late_q <= late_d;
        end
    end

    // Read port, data valid only in the cycle after the strobe
    always_comb begin
        rdata_d = '0;
        if (reg_rd) begin
            if (cmc_hit(reg_addr, CMC_OFF_MODE2)) begin
                rdata_d = mode_q & CMC_MODE2_WMASK;
            end else if (cmc_hit(reg_addr, CMC_OFF_STATUS)) begin
                rdata_d[1:0] = status_q;
            end else if (cmc_hit(reg_addr, CMC_OFF_MASK)) begin
                rdata_d[1:0] = mask_q;
            end else if (cmc_hit(reg_addr, CMC_OFF_NEST)) begin
                rdata_d[CMC_NEST_LATCHED] = nest_latched;
                rdata_d[CMC_NEST_EVENT_MASK] = nest_event_mask;
                rdata_d[CMC_NEST_LOWER_MASK] = nest_lower_mask;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    cmc_event_nest u_nest (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .self_nest_enable(mode_q[CMC_BIT_SELF_NEST]),
        .global_interrupt_enable(global_interrupt_enable),
        .nested_interrupt_enable(nested_interrupt_enable),
        .system_event_irq_req(system_event_irq_req),
        .system_event_irq_ack(system_event_irq_ack),
        .event_in_service(event_in_service),
        .higher_in_service(higher_in_service),
        .latched_q(nest_latched),
        .event_mask_q(nest_event_mask),
        .lower_mask_q(nest_lower_mask)
    );

    assign reg_rdata = rdata_q;
    assign conflict_cache_freeze = mode_q[CMC_BIT_CACHE_FREEZE];
    assign conflict_cache_disable = mode_q[CMC_BIT_CACHE_DISABLE];
    assign cache_fill_allow = fill_q;
    assign slow_loop_debug = mode_q[CMC_BIT_SLOW_LOOP];
    assign late_stage_loop_mode = late_q;
    assign core_timer_run = mode_q[CMC_BIT_TIMER_RUN];
    assign event_irq_self_nest_enable = mode_q[CMC_BIT_SELF_NEST];
    assign system_event_irq_latched = nest_latched;
    assign system_event_irq_masked = nest_event_mask;
    assign lower_irq_masked = nest_lower_mask;
    assign irq = irq_q;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_mode_wr(int b, bit v);
        reg_wr && (reg_addr == CMC_OFF_MODE2) && (reg_wdata[b] == v);
    endsequence

    sequence s_status_quiet;
        !(reg_wr && (reg_addr == CMC_OFF_STATUS));
    endsequence

    sequence s_read_mode;
        reg_rd && (reg_addr == CMC_OFF_MODE2);
    endsequence

    sequence s_wr_elsewhere;
        reg_wr && !cmc_hit(reg_addr, CMC_OFF_MODE2) && !cmc_hit(reg_addr, CMC_OFF_MASK);
    endsequence

    sequence s_read_unmapped;
        reg_rd && !cmc_hit(reg_addr, CMC_OFF_MODE2) && !cmc_hit(reg_addr, CMC_OFF_STATUS)
            && !cmc_hit(reg_addr, CMC_OFF_MASK) && !cmc_hit(reg_addr, CMC_OFF_NEST);
    endsequence

    a_unaligned_flag: assert property (
        long_access_unaligned && mode_q[CMC_BIT_UNALIGNED_EN] |=> status_q[CMC_EVT_UNALIGNED])
        else $error("unaligned access not flagged");

    a_unaligned_off: assert property (
        !status_q[CMC_EVT_UNALIGNED] && !(long_access_unaligned && mode_q[CMC_BIT_UNALIGNED_EN])
        |=> !status_q[CMC_EVT_UNALIGNED])
        else $error("unaligned flag set without enabled event");

    a_illegal_flag: assert property (
        illegal_reg_access && mode_q[CMC_BIT_ILLEGAL_EN] |=> status_q[CMC_EVT_ILLEGAL])
        else $error("illegal access not flagged");

    a_illegal_off: assert property (
        illegal_reg_access && !mode_q[CMC_BIT_ILLEGAL_EN] && !status_q[CMC_EVT_ILLEGAL]
        |=> !status_q[CMC_EVT_ILLEGAL])
        else $error("illegal access flagged while disabled");

    a_sticky_hold: assert property (
        (status_q[CMC_EVT_UNALIGNED] and s_status_quiet) |=> status_q[CMC_EVT_UNALIGNED])
        else $error("sticky flag lost without clear");

    a_freeze_fill: assert property (
        s_mode_wr(CMC_BIT_CACHE_FREEZE, 1'h1) |=> conflict_cache_freeze && !cache_fill_allow)
        else $error("frozen cache still fills");

    a_slow_loop: assert property (
        mode_q[CMC_BIT_SLOW_LOOP] && loop_opcode_early |=> late_stage_loop_mode)
        else $error("slow loop did not override early loop");

    a_timer_run: assert property (
        s_mode_wr(CMC_BIT_TIMER_RUN, 1'h1) |=> core_timer_run ##1 (core_timer_run || $past(wr_mode)))
        else $error("timer not running after enable");

    a_timer_stop: assert property (
        s_mode_wr(CMC_BIT_TIMER_RUN, 1'h0) |=> !core_timer_run)
        else $error("timer still running after disable");

    a_cache_disable: assert property (
        s_mode_wr(CMC_BIT_CACHE_DISABLE, 1'h1) |=> conflict_cache_disable && !cache_fill_allow)
        else $error("cache not disabled");

    a_reserved_zero: assert property (
        s_read_mode |=> (reg_rdata & ~CMC_MODE2_WMASK) == 32'h00000000)
        else $error("reserved mode bits read nonzero");

    a_mode_readback: assert property (
        reg_wr && (reg_addr == CMC_OFF_MODE2) ##1 s_read_mode
        |=> reg_rdata == ($past(reg_wdata, 2) & CMC_MODE2_WMASK))
        else $error("mode readback mismatch");

    a_irq_level: assert property (
        irq == |(status_q & mask_q))
        else $error("interrupt level wrong");

    // Sticky clear and hold
    a_unaligned_clear: assert property (
        reg_wr && (reg_addr == CMC_OFF_STATUS) && reg_wdata[CMC_EVT_UNALIGNED] && !long_access_unaligned
        |=> !status_q[CMC_EVT_UNALIGNED])
        else $error("unaligned flag not cleared by write one");

    a_illegal_clear: assert property (
        reg_wr && (reg_addr == CMC_OFF_STATUS) && reg_wdata[CMC_EVT_ILLEGAL] && !illegal_reg_access
        |=> !status_q[CMC_EVT_ILLEGAL])
        else $error("illegal flag not cleared by write one");

    a_illegal_hold: assert property (
        (status_q[CMC_EVT_ILLEGAL] and s_status_quiet) |=> status_q[CMC_EVT_ILLEGAL])
        else $error("illegal flag lost without clear");

    // Cache and loop control
    a_fill_thaw: assert property (
        (s_mode_wr(CMC_BIT_CACHE_FREEZE, 1'h0) and s_mode_wr(CMC_BIT_CACHE_DISABLE, 1'h0))
        |=> cache_fill_allow)
        else $error("thawed enabled cache refuses fills");

    a_early_kept: assert property (
        !mode_q[CMC_BIT_SLOW_LOOP] && loop_opcode_early |=> !late_stage_loop_mode)
        else $error("early loop forced late without slow loop");

    a_late_default: assert property (
        !loop_opcode_early |=> late_stage_loop_mode)
        else $error("late loop opcode not honoured");

    // Nesting outputs seen at the top
    a_service_mask: assert property (
        event_in_service |=> lower_irq_masked)
        else $error("lower priorities open while event in service");

    a_idle_unmask: assert property (
        !event_in_service |=> !lower_irq_masked && !system_event_irq_masked)
        else $error("masks held with event idle");

    // Bus side
    a_rdata_idle: assert property (
        !reg_rd |=> reg_rdata == 32'h00000000)
        else $error("read data outside read cycle");

    a_status_read: assert property (
        reg_rd && (reg_addr == CMC_OFF_STATUS) |=> reg_rdata == {30'h00000000, $past(status_q)})
        else $error("status readback mismatch");

    a_unmapped_read: assert property (
        s_read_unmapped |=> reg_rdata == 32'h00000000)
        else $error("unmapped read nonzero");

    a_other_wr_quiet: assert property (
        s_wr_elsewhere |=> $stable(mode_q) && $stable(mask_q))
        else $error("write to other address changed mode or mask");

endmodule : cmc_mode_ctrl

/* File: rtl/cmc_pkg.sv */
package cmc_pkg;

    localparam int CMC_ADDR_W = 8;
    localparam int CMC_DATA_W = 32;
    localparam int CMC_EVT_W = 2;

    // Register offsets
    localparam logic [7:0] CMC_OFF_MODE2 = 8'h00;
    localparam logic [7:0] CMC_OFF_STATUS = 8'h04;
    localparam logic [7:0] CMC_OFF_MASK = 8'h08;
    localparam logic [7:0] CMC_OFF_NEST = 8'h0C;

    // Mode control two field positions
    localparam int CMC_BIT_UNALIGNED_EN = 21;
    localparam int CMC_BIT_ILLEGAL_EN = 20;
    localparam int CMC_BIT_CACHE_FREEZE = 19;
    localparam int CMC_BIT_SLOW_LOOP = 7;
    localparam int CMC_BIT_TIMER_RUN = 5;
    localparam int CMC_BIT_CACHE_DISABLE = 4;
    localparam int CMC_BIT_SELF_NEST = 0;

    localparam logic [31:0] CMC_MODE2_WMASK = 32'h003800B1;
    localparam logic [31:0] CMC_MODE2_RESET = 32'h00000000;

    // Sticky status and mask field positions
    localparam int CMC_EVT_UNALIGNED = 0;
    localparam int CMC_EVT_ILLEGAL = 1;
    localparam logic [1:0] CMC_EVT_RESET = 2'h0;

    // Nesting state readback field positions
    localparam int CMC_NEST_LATCHED = 0;
    localparam int CMC_NEST_EVENT_MASK = 1;
    localparam int CMC_NEST_LOWER_MASK = 2;

    function automatic logic cmc_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction : cmc_hit

endpackage : cmc_pkg

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
    import cmc_pkg::*;

    logic clk_sys = 1'h0;
    logic resetn = 1'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic unal = 1'h0;
    logic illeg = 1'h0;
    logic early = 1'h0;
    logic gie = 1'h0;
    logic nest = 1'h0;
    logic req = 1'h0;
    logic ack = 1'h0;
    logic ins = 1'h0;
    logic higher = 1'h0;
    logic freeze, cdis, fill, slow, late, trun, sn, lat, emask, lmask, irq;
    int err_count = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h00000018;
    logic [31:0] r;
    logic [31:0] mode;
    logic [1:0] stat;
    logic exp_lat = 1'h0;
    logic exp_em;

    cmc_mode_ctrl i_cmc_mode_ctrl (
        .clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .long_access_unaligned(unal), .illegal_reg_access(illeg), .loop_opcode_early(early),
        .global_interrupt_enable(gie), .nested_interrupt_enable(nest),
        .system_event_irq_req(req), .system_event_irq_ack(ack),
        .event_in_service(ins), .higher_in_service(higher),
        .conflict_cache_freeze(freeze), .conflict_cache_disable(cdis), .cache_fill_allow(fill),
        .slow_loop_debug(slow), .late_stage_loop_mode(late), .core_timer_run(trun),
        .event_irq_self_nest_enable(sn), .system_event_irq_latched(lat),
        .system_event_irq_masked(emask), .lower_irq_masked(lmask), .irq(irq)
    );

    initial begin
        forever #5 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk32

    task automatic chk1(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk1

    // Entered and left right after a rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        @(posedge clk_sys);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        chk32(reg_rdata, exp);
        @(posedge clk_sys);
    endtask : rd_chk

    // Write, then read back with no idle cycle between
    task automatic wr_rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] exp);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
        reg_rd <= 1'h1;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1;
        chk32(reg_rdata, exp);
        @(posedge clk_sys);
        #1;
        chk32(reg_rdata, 32'h00000000);
    endtask : wr_rd

    task automatic final_report();
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            final_report();
        end
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'h1;
        @(posedge clk_sys);
        #1;
        chk1(fill, 1'h1);
        chk1(late, 1'h1);
        chk1(irq, 1'h0);
        @(posedge clk_sys);
        rd_chk(CMC_OFF_MODE2, 32'h00000000);
        rd_chk(CMC_OFF_STATUS, 32'h00000000);
        rd_chk(CMC_OFF_MASK, 32'h00000000);
        // Mode bits: full, empty, inverted mask, then random words
        for (int i = 0; i < 24; i++) begin
            r = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : (i == 2) ? ~CMC_MODE2_WMASK : xs();
            early <= seed[9];
            mode = r & CMC_MODE2_WMASK;
            wr_rd(CMC_OFF_MODE2, r, mode);
            chk1(freeze, mode[19]);
            chk1(cdis, mode[4]);
            chk1(fill, !mode[19] && !mode[4]);
            chk1(slow, mode[7]);
            chk1(late, mode[7] | !early);
            chk1(trun, mode[5]);
            chk1(sn, mode[0]);
        end
        wr(8'h40, 32'hFFFFFFFF);
        rd_chk(8'h40, 32'h00000000);
        rd_chk(CMC_OFF_MODE2, mode);
        // Sticky events with enables, mask and partial clear
        for (int i = 0; i < 16; i++) begin
            r = (i == 0) ? 32'h000000F3 : (i == 1) ? 32'h000000F0 : xs();
            wr(CMC_OFF_MODE2, {10'h000, r[1], r[0], 20'h00000});
            wr(CMC_OFF_MASK, {30'h00000000, r[3:2]});
            wr(CMC_OFF_STATUS, 32'h00000003);
            unal <= r[4];
            illeg <= r[5];
            @(posedge clk_sys);
            unal <= 1'h0;
            illeg <= 1'h0;
            @(posedge clk_sys);
            stat = {r[5] & r[0], r[4] & r[1]};
            rd_chk(CMC_OFF_STATUS, {30'h00000000, stat});
            chk1(irq, |(stat & r[3:2]));
            wr(CMC_OFF_STATUS, {30'h00000000, r[7:6]});
            stat = stat & ~r[7:6];
            rd_chk(CMC_OFF_STATUS, {30'h00000000, stat});
            chk1(irq, |(stat & r[3:2]));
        end
        // Self nesting and priority masking
        for (int i = 0; i < 48; i++) begin
            r = (i == 0) ? 32'h0000002F : (i == 1) ? 32'h0000003E : xs();
            wr(CMC_OFF_MODE2, {31'h00000000, r[0]});
            gie <= r[1];
            nest <= r[2];
            ins <= r[3];
            higher <= r[4];
            req <= r[5];
            ack <= r[6];
            @(posedge clk_sys);
            req <= 1'h0;
            ack <= 1'h0;
            @(posedge clk_sys);
            #1;
            exp_lat = (r[5] && (!r[3] || r[0])) ? 1'h1 : (r[6] ? 1'h0 : exp_lat);
            exp_em = r[3] & (r[4] | !(r[0] & r[1] & r[2]));
            chk1(lat, exp_lat);
            chk1(emask, exp_em);
            chk1(lmask, r[3]);
            @(posedge clk_sys);
            rd_chk(CMC_OFF_NEST, {29'h00000000, r[3], exp_em, exp_lat});
        end
        final_report();
    end
endmodule : testbench
